// ===== shared/async_timer_consts.svh
// register offsets, field positions and reset values of the timer status block
// assumes an 8-bit cpu register bus with separate data and i/o spaces
`ifndef ASYNC_TIMER_CONSTS_SVH
`define ASYNC_TIMER_CONSTS_SVH

// ---------------------------------------------------------------------------
// data-space offsets
// ---------------------------------------------------------------------------
`define OFS_EVENT_FLAGS     8'h37
`define OFS_SYNC_CONTROL    8'h43
`define OFS_IRQ_MASK        8'h70
`define OFS_CONTROL_A       8'hb0
`define OFS_CONTROL_B       8'hb1
`define OFS_COUNT_VALUE     8'hb2
`define OFS_COMPARE_A       8'hb3
`define OFS_COMPARE_B       8'hb4
`define OFS_ASYNC_STATUS    8'hb6

// ---------------------------------------------------------------------------
// i/o-space window
// ---------------------------------------------------------------------------
`define IO_SPACE_BASE       8'h20
`define IO_SPACE_LIMIT      8'h60

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define BIT_OVERFLOW        0
`define BIT_MATCH_A         1
`define BIT_MATCH_B         2
`define BIT_EXT_CLK_EN      6
`define BIT_ASYNC_SEL       5
`define BIT_TIMER_SYNC_HOLD 7
`define BIT_ASYNC_PSC_RST   1
`define BIT_SHARED_PSC_RST  0

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define RST_EVENT_FLAGS     3'h0
`define RST_IRQ_MASK        3'h0
`define RST_ASYNC_STATUS    2'h0
`define RST_BUSY            5'h00
`define RST_SYNC_CONTROL    1'h0
`define RST_BYTE            8'h00

`endif

// ===== shared/async_timer_pkg.sv
// types shared by the timer status block
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package async_timer_pkg;
   typedef logic [7:0] byte_t;
   // index of each update-busy bit in the status register
   typedef enum logic [2:0] {
      busy_control_b,
      busy_control_a,
      busy_compare_b,
      busy_compare_a,
      busy_count
   } busy_idx_t;
endpackage
`default_nettype wire

// ===== sim/async_timer_status_monitor.sv
// port checker for the timer status block
// assumes it is bound onto async_timer_status
`timescale 1ns/10ps
`default_nettype none
module async_timer_status_monitor (
   // watched inputs
   input wire logic       i_ref_clk,
   input wire logic       i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic       i_io_space,
   input wire logic       i_wr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_global_irq_enable,
   input wire logic       i_overflow_evt,
   input wire logic       i_bottom_turn_evt,
   input wire logic       i_phase_correct,
   input wire logic       i_match_a_evt,
   input wire logic       i_match_b_evt,
   // watched outputs
   input wire logic [2:0] o_irq_req,
   input wire logic       o_async_clock_select,
   input wire logic       o_ext_clk_buf_en,
   input wire logic       o_xtal_osc_en,
   input wire logic       o_shared_psc_reset
);
   // ----
   // shadow of mask and hold bit
   // ----
   logic [2:0] mask_q;
   logic       hold_q;
   logic       ovf_evt;
   logic       sync_wr;
   assign ovf_evt = i_phase_correct ? i_bottom_turn_evt : i_overflow_evt;
   assign sync_wr = i_wr && (i_io_space ? i_addr == 8'h23 : i_addr == 8'h43);
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mask_q <= 3'h0;
         hold_q <= 1'h0;
      end else begin
         if (i_wr && !i_io_space && i_addr == 8'h70) mask_q <= i_wdata[2:0];
         if (sync_wr) hold_q <= i_wdata[7];
      end
   end
   default clocking dc @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   irq_gate_a: assert property (!$past(i_global_irq_enable) |-> o_irq_req == 3'h0)
      else $error("interrupt without global enable");
   mask_gate_a: assert property ((o_irq_req & ~$past(mask_q)) == 3'h0)
      else $error("interrupt without its enable");
   ovf_irq_a: assert property (ovf_evt && i_global_irq_enable ##1 i_global_irq_enable && mask_q[0]
      |=> o_irq_req[0]) else $error("overflow request missing");
   match_a_irq_a: assert property (i_match_a_evt && i_global_irq_enable ##1 i_global_irq_enable
      && mask_q[1] |=> o_irq_req[1]) else $error("match a request missing");
   match_b_irq_a: assert property (i_match_b_evt && i_global_irq_enable ##1 i_global_irq_enable
      && mask_q[2] |=> o_irq_req[2]) else $error("match b request missing");
   clk_excl_a: assert property (o_ext_clk_buf_en |-> o_async_clock_select && !o_xtal_osc_en)
      else $error("buffer and crystal both on");
   sel_follow_a: assert property (i_wr && !i_io_space && i_addr == 8'hb6
      |-> ##2 o_async_clock_select == $past(i_wdata[5], 2)) else $error("select not followed");
   xtal_follow_a: assert property (i_wr && !i_io_space && i_addr == 8'hb6
      |-> ##2 o_xtal_osc_en == ($past(i_wdata[5], 2) && !$past(i_wdata[6], 2))) else $error("crystal wrong");
   shared_pulse_a: assert property (sync_wr && !i_wdata[7] && i_wdata[0]
      |-> ##[1:2] o_shared_psc_reset ##[1:2] !o_shared_psc_reset) else $error("shared reset not pulsed");
   hold_keep_a: assert property (hold_q && o_shared_psc_reset && !sync_wr && !$past(sync_wr)
      |=> o_shared_psc_reset) else $error("held reset dropped");
   cover property (o_irq_req == 3'h7);
   cover property (o_ext_clk_buf_en);
   cover property (hold_q && o_shared_psc_reset);
endmodule
bind async_timer_status async_timer_status_monitor mon (.*);
`default_nettype wire

// ===== sim/async_timer_status_test.sv
// self-checking bench for the timer status block
// assumes the block alone, inputs driven on the falling edge
`timescale 1ns/10ps
`default_nettype none
module async_timer_status_test;
   logic       i_ref_clk, i_nrst, i_io_space, i_wr, i_rd, i_global_irq_enable;
   logic       i_overflow_evt, i_bottom_turn_evt, i_phase_correct, i_match_a_evt, i_match_b_evt;
   logic       i_async_psc_reset_done, o_async_clock_select, o_ext_clk_buf_en, o_xtal_osc_en;
   logic       o_async_psc_reset, o_shared_psc_reset;
   logic [2:0] i_vector_ack, o_irq_req;
   logic [4:0] i_xfer_done_toggle;
   logic [7:0] i_addr, i_wdata, o_rdata;
   int         bad_count = 0;
   int         compares = 0;
   int         cycles = 0;
   async_timer_status uut (.*);
   // ----
   // bus, event and check tasks
   // ----
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b0);
      @(negedge i_ref_clk);
      {i_io_space, i_addr, i_wdata, i_wr} = {io, a, d, 1'b1};
      @(negedge i_ref_clk);
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic io = 1'b0);
      @(negedge i_ref_clk);
      {i_io_space, i_addr, i_rd} = {io, a, 1'b1};
      @(negedge i_ref_clk);
      i_rd = 1'b0;
      chk("rdata", o_rdata, exp);
   endtask
   task automatic ev(input logic [6:0] e);
      @(negedge i_ref_clk);
      {i_vector_ack, i_match_b_evt, i_match_a_evt, i_bottom_turn_evt, i_overflow_evt} = e;
      @(negedge i_ref_clk);
      {i_vector_ack, i_match_b_evt, i_match_a_evt, i_bottom_turn_evt, i_overflow_evt} = 7'h00;
   endtask
   task automatic outs(input logic [7:0] exp);
      repeat (2) @(negedge i_ref_clk);
      chk("outputs", {o_irq_req, o_async_clock_select, o_ext_clk_buf_en, o_xtal_osc_en,
                      o_async_psc_reset, o_shared_psc_reset}, exp);
   endtask
   task automatic close_out;
      if (bad_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         close_out;
      end
   end
   initial begin
      {i_nrst, i_io_space, i_wr, i_rd, i_global_irq_enable, i_phase_correct} = 6'h00;
      {i_vector_ack, i_match_b_evt, i_match_a_evt, i_bottom_turn_evt, i_overflow_evt} = 7'h00;
      {i_addr, i_wdata, i_xfer_done_toggle, i_async_psc_reset_done} = 22'h0;
      repeat (20) @(negedge i_ref_clk);
      i_nrst = 1'b1;
      rd(8'h37, 8'h00);
      rd(8'hb6, 8'h00);
      rd(8'h23, 8'h00, 1'b1);
      wr(8'h70, 8'h07);
      ev(7'h0d);
      rd(8'h37, 8'h07);
      outs(8'h00);
      i_global_irq_enable = 1'b1;
      outs(8'he0);
      ev(7'h0d);
      wr(8'h17, 8'h02, 1'b1);
      rd(8'h37, 8'h05);
      ev(7'h24);
      rd(8'h37, 8'h07);
      ev(7'h20);
      rd(8'h37, 8'h05);
      wr(8'h37, 8'h00);
      ev(7'h40);
      rd(8'h37, 8'h01);
      outs(8'h20);
      wr(8'h37, 8'h01);
      rd(8'h37, 8'h00);
      i_phase_correct = 1'b1;
      ev(7'h02);
      rd(8'h37, 8'h01);
      ev(7'h11);
      rd(8'h37, 8'h00);
      i_phase_correct = 1'b0;
      rd(8'h00, 8'h00);
      wr(8'h96, 8'h60, 1'b1);
      rd(8'hb6, 8'h00);
      wr(8'hb6, 8'h40);
      wr(8'hb6, 8'h60);
      outs(8'h18);
      for (int i = 0; i < 5; i++) begin
         wr(8'hb0 + i[7:0], 8'h00);
      end
      rd(8'hb6, 8'h7f);
      for (int i = 4; i >= 0; i--) begin
         i_xfer_done_toggle[i] = ~i_xfer_done_toggle[i];
         repeat (4) @(negedge i_ref_clk);
         rd(8'hb6, 8'h60 | (8'h1f >> (5 - i)));
      end
      wr(8'hb6, 8'h20);
      outs(8'h14);
      wr(8'h43, 8'h02);
      rd(8'h43, 8'h02);
      outs(8'h16);
      i_async_psc_reset_done = 1'b1;
      rd(8'h43, 8'h00);
      i_async_psc_reset_done = 1'b0;
      wr(8'hb6, 8'h00);
      wr(8'hb2, 8'h00);
      rd(8'hb6, 8'h00);
      outs(8'h00);
      wr(8'h43, 8'h01);
      rd(8'h43, 8'h00);
      wr(8'h43, 8'h02);
      rd(8'h43, 8'h00);
      wr(8'h43, 8'h83);
      rd(8'h23, 8'h83, 1'b1);
      outs(8'h03);
      wr(8'h23, 8'h00, 1'b1);
      outs(8'h00);
      rd(8'h43, 8'h00);
      wr(8'h70, 8'h07);
      ev(7'h01);
      i_nrst = 1'b0;
      repeat (2) @(negedge i_ref_clk);
      i_nrst = 1'b1;
      rd(8'h70, 8'h00);
      rd(8'h37, 8'h00);
      outs(8'h00);
      close_out;
   end
endmodule
`default_nettype wire

// ===== verilog/async_timer_status.sv
// status, flag and prescaler control around an 8-bit asynchronous timer
// assumes cpu bus strobes and timer-core events other than i_xfer_done_toggle are synchronous to i_ref_clk
`include "async_timer_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module async_timer_status
   import async_timer_pkg::*;
(
   // clock and reset
   input  wire  logic       i_ref_clk,
   input  wire  logic       i_nrst,
   // cpu register port
   input  wire  logic [7:0] i_addr,
   input  wire  logic       i_io_space,
   input  wire  logic       i_wr,
   input  wire  logic       i_rd,
   input  wire  logic [7:0] i_wdata,
   output logic       [7:0] o_rdata,
   // cpu interrupt side
   input  wire  logic       i_global_irq_enable,
   input  wire  logic [2:0] i_vector_ack,
   output logic       [2:0] o_irq_req,
   // timer core events
   input  wire  logic       i_overflow_evt,
   input  wire  logic       i_bottom_turn_evt,
   input  wire  logic       i_phase_correct,
   input  wire  logic       i_match_a_evt,
   input  wire  logic       i_match_b_evt,
   input  wire  logic [4:0] i_xfer_done_toggle,
   input  wire  logic       i_async_psc_reset_done,
   // clocking and prescaler controls
   output logic             o_async_clock_select,
   output logic             o_ext_clk_buf_en,
   output logic             o_xtal_osc_en,
   output logic             o_async_psc_reset,
   output logic             o_shared_psc_reset
);

   // ------------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------------
   function automatic logic hit_data(input byte_t ofs);
      hit_data = !i_io_space && (i_addr == ofs);
   endfunction

   // registers inside the low i/o window answer at offset minus base too
   function automatic logic hit_both(input byte_t ofs);
      byte_t io_ofs;
      io_ofs = ofs - `IO_SPACE_BASE;
      hit_both = hit_data(ofs) ||
                 (i_io_space && ofs >= `IO_SPACE_BASE && ofs < `IO_SPACE_LIMIT && i_addr == io_ofs);
   endfunction

   logic hit_flags;
   logic hit_sync;
   logic hit_mask;
   logic hit_status;
   logic [4:0] hit_busy;

   always_comb begin
      hit_flags  = hit_both(`OFS_EVENT_FLAGS);
      hit_sync   = hit_both(`OFS_SYNC_CONTROL);
      hit_mask   = hit_data(`OFS_IRQ_MASK);
      hit_status = hit_data(`OFS_ASYNC_STATUS);
      hit_busy[busy_count]     = hit_data(`OFS_COUNT_VALUE);
      hit_busy[busy_compare_a] = hit_data(`OFS_COMPARE_A);
      hit_busy[busy_compare_b] = hit_data(`OFS_COMPARE_B);
      hit_busy[busy_control_a] = hit_data(`OFS_CONTROL_A);
      hit_busy[busy_control_b] = hit_data(`OFS_CONTROL_B);
   end

   // ------------------------------------------------------------------------
   // write strobes
   // ------------------------------------------------------------------------
   logic wr_flags;
   logic wr_sync;
   logic wr_mask;
   logic wr_status;

   always_comb begin
      wr_flags  = i_wr && hit_flags;
      wr_sync   = i_wr && hit_sync;
      wr_mask   = i_wr && hit_mask;
      wr_status = i_wr && hit_status;
   end

   // ------------------------------------------------------------------------
   // event flags
   // ------------------------------------------------------------------------
   logic [2:0] event_flags;
   logic [2:0] next_flags;
   logic [2:0] irq_mask;
   logic [2:0] irq_pending;
   logic [2:0] flag_set;
   logic [2:0] flag_w1c;
   logic [2:0] flag_clr;

   always_comb begin
      flag_set[`BIT_OVERFLOW] = i_phase_correct ? i_bottom_turn_evt : i_overflow_evt;
      flag_set[`BIT_MATCH_A]  = i_match_a_evt;
      flag_set[`BIT_MATCH_B]  = i_match_b_evt;
      // software clears a flag by writing one to it
      flag_w1c    = wr_flags ? i_wdata[2:0] : 3'h0;
      flag_clr    = i_vector_ack | flag_w1c;
      // set wins over a clear in the same cycle
      next_flags  = (event_flags & ~flag_clr) | flag_set;
      irq_pending = event_flags & irq_mask & {3{i_global_irq_enable}};
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         event_flags <= `RST_EVENT_FLAGS;
      end else begin
         event_flags <= next_flags;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_mask <= `RST_IRQ_MASK;
      end else if (wr_mask) begin
         irq_mask <= i_wdata[2:0];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq_req <= 3'h0;
      end else begin
         o_irq_req <= irq_pending;
      end
   end

   // ------------------------------------------------------------------------
   // clock selection
   // ------------------------------------------------------------------------
   logic ext_clk_en;
   logic async_sel;

   // software is expected to set the external enable before selecting async
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {ext_clk_en, async_sel} <= `RST_ASYNC_STATUS;
      end else if (wr_status) begin
         ext_clk_en <= i_wdata[`BIT_EXT_CLK_EN];
         async_sel  <= i_wdata[`BIT_ASYNC_SEL];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_async_clock_select <= 1'b0;
         o_ext_clk_buf_en     <= 1'b0;
         o_xtal_osc_en        <= 1'b0;
      end else begin
         o_async_clock_select <= async_sel;
         o_ext_clk_buf_en     <= async_sel && ext_clk_en;
         o_xtal_osc_en        <= async_sel && !ext_clk_en;
      end
   end

   // ------------------------------------------------------------------------
   // update-busy tracking
   // ------------------------------------------------------------------------
   logic [4:0] done_meta;
   logic [4:0] done_sync;
   logic [4:0] done_last;
   logic [4:0] busy;
   logic [4:0] busy_set;
   logic [4:0] busy_clr;
   logic [4:0] next_busy;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         done_meta <= 5'h00;
         done_sync <= 5'h00;
         done_last <= 5'h00;
      end else begin
         done_meta <= i_xfer_done_toggle;
         done_sync <= done_meta;
         done_last <= done_sync;
      end
   end

   always_comb begin
      busy_set = (i_wr && async_sel) ? hit_busy : 5'h00;
      busy_clr = done_sync ^ done_last;
      // a new write wins over a transfer finishing in the same cycle
      next_busy = (busy & ~busy_clr) | busy_set;
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy <= `RST_BUSY;
      end else begin
         busy <= next_busy;
      end
   end

   // ------------------------------------------------------------------------
   // prescaler reset and synchronisation mode
   // ------------------------------------------------------------------------
   logic timer_sync_hold;
   logic async_psc_reset;
   logic shared_psc_reset;
   logic async_psc_kick;
   logic shared_psc_kick;

   always_comb begin
      // a written one reaches the prescaler even when the stored bit clears at once
      async_psc_kick  = wr_sync && i_wdata[`BIT_ASYNC_PSC_RST];
      shared_psc_kick = wr_sync && i_wdata[`BIT_SHARED_PSC_RST];
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         timer_sync_hold  <= `RST_SYNC_CONTROL;
         async_psc_reset  <= `RST_SYNC_CONTROL;
         shared_psc_reset <= `RST_SYNC_CONTROL;
      end else if (wr_sync) begin
         timer_sync_hold <= i_wdata[`BIT_TIMER_SYNC_HOLD];
         if (!i_wdata[`BIT_TIMER_SYNC_HOLD]) begin
            shared_psc_reset <= 1'b0;
            if (timer_sync_hold || !async_sel) begin
               // leaving sync mode releases both prescalers together
               async_psc_reset <= 1'b0;
            end else begin
               // stays up until the timer domain reports the reset done
               async_psc_reset <= i_wdata[`BIT_ASYNC_PSC_RST];
            end
         end else begin
            async_psc_reset  <= i_wdata[`BIT_ASYNC_PSC_RST];
            shared_psc_reset <= i_wdata[`BIT_SHARED_PSC_RST];
         end
      end else if (!timer_sync_hold) begin
         shared_psc_reset <= 1'b0;
         if (!async_sel || i_async_psc_reset_done) begin
            async_psc_reset <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_async_psc_reset  <= 1'b0;
         o_shared_psc_reset <= 1'b0;
      end else begin
         o_async_psc_reset  <= async_psc_reset | async_psc_kick;
         o_shared_psc_reset <= shared_psc_reset | shared_psc_kick;
      end
   end

   // ------------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------------
   byte_t next_rdata;

   // unmapped addresses read as zero
   always_comb begin
      if (hit_flags) begin
         next_rdata = {5'h00, event_flags};
      end else if (hit_mask) begin
         next_rdata = {5'h00, irq_mask};
      end else if (hit_status) begin
         next_rdata = {1'b0, ext_clk_en, async_sel, busy};
      end else if (hit_sync) begin
         next_rdata = {timer_sync_hold, 5'h00, async_psc_reset, shared_psc_reset};
      end else begin
         next_rdata = `RST_BYTE;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= `RST_BYTE;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end
   end

endmodule

`default_nettype wire
